// *** rnpc_reset_nmi_pin_control.sv ***
// reset input, reset indication, nmi trap and power-down gating
// Behaviour
// - low reset pin for minimum time resets
// - bidirectional mode drives reset pin during sequence
// - indication low on hw, sw, watchdog reset
// - indication released only after end-of-init
// - nmi falling edge requests trap
// - powerdown entered when nmi low, config zero
// - powerdown ignored when nmi high, config zero
// - timing pin selects reset mode, wake timing
`timescale 1ns/1ps
`default_nettype none
`include "rnpc_defines.svh"
module rnpc_reset_nmi_pin_control #(
  parameter int SEQ_CYC = `RNPC_SEQ_CYC,
  parameter int MIN_CYC = `RNPC_RST_MIN_CYC
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // pins
  input  wire logic              reset_in_pin_i,
  output logic                   reset_in_pin_o,
  output logic                   reset_in_pin_oe_n_o,
  output logic                   reset_indication_out_o,
  input  wire logic              nonmaskable_irq_pin_i,
  input  wire logic              powerdown_timing_pin_i,
  // cpu side
  input  wire rnpc_pkg::rnpc_cpu_s cpu_i,
  input  wire logic              bidir_reset_enable_i,
  input  wire logic              powerdown_config_bit_i,
  output logic                   nmi_trap_o,
  output logic                   powerdown_o,
  output logic                   core_reset_o,
  output logic                   async_reset_sel_o,
  output logic                   wake_timing_o
);
  logic [1:0] rst_sync_r, nmi_sync_r, rpd_sync_r;
  logic       nmi_prev_r;
  logic [`RNPC_CNT_W-1:0] low_cnt_r, seq_cnt_r;
  rnpc_pkg::rnpc_state_e state_r;
  logic       hw_reset;
  logic [2:0] drive_hist_r;
  logic       own_mask;

  // two stages; only stage one feeds stage two
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_r <= 2'h3;
      nmi_sync_r <= 2'h3;
      rpd_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], reset_in_pin_i};
      nmi_sync_r <= {nmi_sync_r[0], nonmaskable_irq_pin_i};
      rpd_sync_r <= {rpd_sync_r[0], powerdown_timing_pin_i};
    end
  end

  // short glitches on the reset pin are filtered by the low count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_cnt_r <= '0;
    end else if (rst_sync_r[1]) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r < MIN_CYC[`RNPC_CNT_W-1:0]) begin
      low_cnt_r <= low_cnt_r + 1'b1;
    end
  end
  // history of own drive, long enough to cover the synchroniser lag
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drive_hist_r <= 3'h0;
    end else begin
      drive_hist_r <= {drive_hist_r[1:0], !reset_in_pin_oe_n_o};
    end
  end
  // own drive of the pin is masked, else bidir mode would latch up
  // limitation: an external pulse inside the mask window is not seen
  assign own_mask = (state_r == rnpc_pkg::RNPC_SEQ) || !reset_in_pin_oe_n_o || (|drive_hist_r);
  assign hw_reset = (low_cnt_r >= MIN_CYC[`RNPC_CNT_W-1:0] - 1'b1) && !rst_sync_r[1]
                    && !own_mask;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r   <= rnpc_pkg::RNPC_SEQ;
      seq_cnt_r <= '0;
    end else begin
      case (state_r)
        rnpc_pkg::RNPC_SEQ: begin
          if (seq_cnt_r >= SEQ_CYC[`RNPC_CNT_W-1:0] - 1'b1) begin
            state_r <= rnpc_pkg::RNPC_INIT;
          end else begin
            seq_cnt_r <= seq_cnt_r + 1'b1;
          end
        end
        rnpc_pkg::RNPC_INIT: begin
          if (hw_reset || cpu_i.sw_reset || cpu_i.wdt_reset) begin
            state_r   <= rnpc_pkg::RNPC_SEQ;
            seq_cnt_r <= '0;
          end else if (cpu_i.end_of_init_instr) begin
            state_r <= rnpc_pkg::RNPC_RUN;
          end
        end
        rnpc_pkg::RNPC_RUN: begin
          if (hw_reset || cpu_i.sw_reset || cpu_i.wdt_reset) begin
            state_r   <= rnpc_pkg::RNPC_SEQ;
            seq_cnt_r <= '0;
          end
        end
        default: begin
          state_r   <= rnpc_pkg::RNPC_SEQ;
          seq_cnt_r <= '0;
        end
      endcase
    end
  end

  // pin outputs registered
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reset_indication_out_o <= 1'b0;
      reset_in_pin_o         <= 1'b0;
      reset_in_pin_oe_n_o    <= 1'b1;
      core_reset_o           <= 1'b1;
    end else begin
      reset_indication_out_o <= (state_r == rnpc_pkg::RNPC_RUN) && !cpu_i.sw_reset
                                && !cpu_i.wdt_reset && !hw_reset;
      reset_in_pin_o         <= 1'b0;
      reset_in_pin_oe_n_o    <= !(bidir_reset_enable_i && state_r == rnpc_pkg::RNPC_SEQ);
      core_reset_o           <= (state_r == rnpc_pkg::RNPC_SEQ);
    end
  end

  // nmi edge and power-down gating
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nmi_prev_r  <= 1'b1;
      nmi_trap_o  <= 1'b0;
      powerdown_o <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_sync_r[1];
      nmi_trap_o <= nmi_prev_r && !nmi_sync_r[1];
      if (state_r != rnpc_pkg::RNPC_RUN) begin
        powerdown_o <= 1'b0;
      end else if (cpu_i.powerdown_instr) begin
        // config one: nmi does not gate entry
        powerdown_o <= powerdown_config_bit_i || !nmi_sync_r[1];
      end
    end
  end

  // timing pin level selects reset style and wake timing
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      async_reset_sel_o <= 1'b0;
      wake_timing_o     <= 1'b0;
    end else begin
      async_reset_sel_o <= rpd_sync_r[1];
      wake_timing_o     <= rpd_sync_r[1];
    end
  end

  a_nmi_edge_trap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(nmi_sync_r[1]) |=> nmi_trap_o) else $error("nmi edge lost");
  a_pd_nmi_high: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == rnpc_pkg::RNPC_RUN && cpu_i.powerdown_instr && !powerdown_config_bit_i && nmi_sync_r[1])
    |=> !powerdown_o) else $error("powerdown not ignored");
  a_pd_nmi_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == rnpc_pkg::RNPC_RUN && cpu_i.powerdown_instr && !nmi_sync_r[1])
    |=> powerdown_o) else $error("powerdown not entered");
  a_bidir_drive: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == rnpc_pkg::RNPC_SEQ && bidir_reset_enable_i) |=> !reset_in_pin_oe_n_o)
    else $error("reset pin not driven");
  a_sw_rst_ind: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (cpu_i.sw_reset || cpu_i.wdt_reset) |=> !reset_indication_out_o[*2])
    else $error("indication not low");
  a_init_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(reset_indication_out_o) |-> $past(cpu_i.end_of_init_instr, 2))
    else $error("released without end of init");
  a_hw_reset_seq: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (hw_reset && state_r != rnpc_pkg::RNPC_SEQ) |=> state_r == rnpc_pkg::RNPC_SEQ)
    else $error("pin reset missed");
  a_rpd_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> async_reset_sel_o == $past(rpd_sync_r[1]))
    else $error("timing pin not followed");
  a_sync_path: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(nmi_sync_r[1]) |-> $past(nmi_sync_r[0]) == 1'b0)
    else $error("sync skipped");
  // own release of the pin must not restart the sequence
  a_no_relatch: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (|drive_hist_r && state_r != rnpc_pkg::RNPC_SEQ && !cpu_i.sw_reset && !cpu_i.wdt_reset)
    |=> state_r != rnpc_pkg::RNPC_SEQ) else $error("own drive retriggered");
  a_pin_low_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !reset_in_pin_o) else $error("reset pin driven high");
  a_core_rst_seq: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> core_reset_o == $past(state_r == rnpc_pkg::RNPC_SEQ))
    else $error("core reset wrong");
  a_ind_run_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    reset_indication_out_o |-> $past(state_r == rnpc_pkg::RNPC_RUN))
    else $error("indication high outside run");
  a_trap_single: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    nmi_trap_o |=> !nmi_trap_o)
    else $error("trap longer than one cycle");
  a_pd_cleared: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r != rnpc_pkg::RNPC_RUN) |=> !powerdown_o)
    else $error("powerdown kept through reset");
  a_low_cnt_sat: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    low_cnt_r <= MIN_CYC[`RNPC_CNT_W-1:0])
    else $error("low count overran");
  a_seq_bound: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == rnpc_pkg::RNPC_SEQ) |-> seq_cnt_r < SEQ_CYC[`RNPC_CNT_W-1:0])
    else $error("sequence count overran");
  a_wake_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> wake_timing_o == $past(rpd_sync_r[1]))
    else $error("wake timing not followed");
endmodule
`default_nettype wire

// *** rnpc_defines.svh ***
// constants for the reset and nmi pin controller
`ifndef RNPC_DEFINES_SVH
`define RNPC_DEFINES_SVH
`define RNPC_CLK_PERIOD_NS     10
`define RNPC_RST_MIN_NS        500
`define RNPC_RST_MIN_CYC       ((`RNPC_RST_MIN_NS + `RNPC_CLK_PERIOD_NS - 1) / `RNPC_CLK_PERIOD_NS)
`define RNPC_SEQ_NS            1000
`define RNPC_SEQ_CYC           ((`RNPC_SEQ_NS + `RNPC_CLK_PERIOD_NS - 1) / `RNPC_CLK_PERIOD_NS)
`define RNPC_CNT_W             16
`endif

// *** rnpc_pkg.sv ***
// types for the reset and nmi pin controller
`default_nettype none
package rnpc_pkg;
  // gray along seq, init, run
  typedef enum logic [1:0] {
    RNPC_RUN  = 2'h2,
    RNPC_SEQ  = 2'h1,
    RNPC_INIT = 2'h3
  } rnpc_state_e;

  typedef struct packed {
    logic sw_reset;
    logic wdt_reset;
    logic end_of_init_instr;
    logic powerdown_instr;
  } rnpc_cpu_s;
endpackage
`default_nettype wire

// *** rnpc_board.sv ***
// board model: reset pin with pull-up and nmi source
`timescale 1ns/1ps
`default_nettype none
module rnpc_board (
  // device side of the reset pin
  input  wire logic dev_o_i,
  input  wire logic dev_oe_n_i,
  // board controls
  input  wire logic ext_low_i,
  input  wire logic nmi_low_i,
  // resolved pin levels
  output logic      reset_pin_o,
  output logic      nmi_pin_o
);
  // pull-up holds the pin high unless someone pulls low
  assign reset_pin_o = ((!dev_oe_n_i && !dev_o_i) || ext_low_i) ? 1'h0 : 1'h1;
  assign nmi_pin_o   = !nmi_low_i;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// testbench for the reset and nmi pin controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic clk_i = 1'h0, arst_n_i = 1'h0, ext_low = 1'h0, nmi_low = 1'h0, tpin = 1'h0, bidir = 1'h0, pdcfg = 1'h0;
  rnpc_pkg::rnpc_cpu_s cpu = '0;
  wire logic rst_pin, nmi_pin, pin_o, oe_n, ind, trap, pd, core_rst, sel, wake;
  int bad_count = 0, comparisons = 0, seen, n;
  initial forever #5 clk_i = ~clk_i;
  rnpc_board brd_u (.dev_o_i(pin_o), .dev_oe_n_i(oe_n), .ext_low_i(ext_low), .nmi_low_i(nmi_low),
                    .reset_pin_o(rst_pin), .nmi_pin_o(nmi_pin));
  // short counts keep the run brief
  rnpc_reset_nmi_pin_control #(.SEQ_CYC(4), .MIN_CYC(2)) dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reset_in_pin_i(rst_pin), .reset_in_pin_o(pin_o), .reset_in_pin_oe_n_o(oe_n), .reset_indication_out_o(ind),
    .nonmaskable_irq_pin_i(nmi_pin), .powerdown_timing_pin_i(tpin), .cpu_i(cpu), .bidir_reset_enable_i(bidir),
    .powerdown_config_bit_i(pdcfg), .nmi_trap_o(trap), .powerdown_o(pd), .core_reset_o(core_rst),
    .async_reset_sel_o(sel), .wake_timing_o(wake));
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse(input logic [3:0] v);
    cpu = v;
    tick(1);
    cpu = '0;
  endtask
  // waits out the sequence, noting any own drive of the reset pin
  task automatic recover(input logic b);
    seen = 0;
    for (n = 0; n < 200 && !(core_rst === 1'h0 && n > 6); n++) begin
      tick(1);
      if (oe_n === 1'h0) seen = 1;
    end
    `CHK("pin drive", b, seen[0])
    `CHK("pin level", 1'h0, pin_o)
    `CHK("ind before init", 1'h0, ind)
    `CHK("core out of reset", 1'h0, core_rst)
    pulse(4'h2);
    tick(2);
    `CHK("ind after init", 1'h1, ind)
  endtask
  task automatic end_sim;
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    tick(8);
    arst_n_i = 1'h1;
    recover(1'h0);
    for (int k = 0; k < 3; k++) begin
      bidir = (k != 1);
      if (k == 0) begin
        ext_low = 1'h1;
        tick(7);
        `CHK("ind hw", 1'h0, ind)
        ext_low = 1'h0;
      end else begin
        pulse(k == 1 ? 4'h8 : 4'h4);
        tick(1);
        `CHK("ind sw wdt", 1'h0, ind)
        `CHK("core in reset", 1'h1, core_rst)
      end
      recover(bidir);
    end
    nmi_low = 1'h1;
    seen = 0;
    repeat (8) begin
      tick(1);
      if (trap === 1'h1) seen++;
    end
    `CHK("trap count", 1, seen)
    pulse(4'h1);
    tick(1);
    `CHK("pd nmi low", 1'h1, pd)
    // a reset clears power-down before the refused case
    pulse(4'h8);
    recover(1'h1);
    nmi_low = 1'h0;
    tick(4);
    pulse(4'h1);
    tick(1);
    `CHK("pd nmi high", 1'h0, pd)
    pdcfg = 1'h1;
    pulse(4'h1);
    tick(1);
    `CHK("pd cfg one", 1'h1, pd)
    tpin = 1'h1;
    tick(4);
    `CHK("timing pin", 2'h3, {sel, wake})
    end_sim;
  end
  initial begin
    #20000;
    bad_count++;
    end_sim;
  end
endmodule
`default_nettype wire
